//--- common/uart_rx_regs.svh
// Function
// - Missing stop bit, noise loss or break gives a framing error
// - Framing error sets its flag, word still moves to the data register
// - Framing error clears only by status read then data read
// - Transmit and receive rates are divided from core clock, independently after the shared base stage
// - Two-bit select picks shared base divisor 1, 3, 4 or 13
// - Three-bit transmit and receive selects pick power-of-two 1 to 128
// - Fine prescaler divides further by 1 to 255, separate per path
// - A zero fine factor bypasses that path's fine prescaler
// - Muted receiver sets no reception flags and raises no interrupts
// - Idle-line wake-up clears mute without setting the idle flag
// - Address-mark wake-up on MSB one clears mute and sets receive-full
// - Frame layout follows word length and parity enable settings
// - Address mark tests the top data bit, never the parity bit
// - Parity makes ones count even, or odd when odd select is set
// - Transmitter puts parity in place of the written word's top bit
// - Receiver checks parity, sets parity error, interrupt when enabled
// - Sixteen samples per bit, majority of 8, 9, 10, noise on disagree
// - Sample counter resynchronises on every start bit
// - Start noise unless three ones precede edge, or samples 3,5,7 high
// - Start noise also when any of samples 8, 9 or 10 is high
// - False start discards frame, noise held for the next valid frame
`ifndef UART_RX_REGS_SVH
`define UART_RX_REGS_SVH
`define BASE_DIV_SEL1        4'h1
`define BASE_DIV_SEL3        4'h3
`define BASE_DIV_SEL4        4'h4
`define BASE_DIV_SEL13       4'hD
`define SAMPLES_PER_BIT      5'h10
`define SMP_IDX_3            4'h2
`define SMP_IDX_5            4'h4
`define SMP_IDX_7            4'h6
`define SMP_IDX_8            4'h7
`define SMP_IDX_9            4'h8
`define SMP_IDX_10           4'h9
`define SMP_IDX_LAST         4'hF
`define DATA_BITS_SHORT      4'h8
`define DATA_BITS_LONG       4'h9
`define RESET_MUTE           1'b0
`define RESET_LINE           1'b1
`endif

//--- common/uart_rx_pkg.sv
package uart_rx_pkg;
  typedef enum logic [1:0] {
    RX_HUNT  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_e;
  typedef logic [8:0] word_t;
endpackage : uart_rx_pkg

//--- hdl/uart_rx_baud_parity_mute.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_regs.svh"
module uart_rx_baud_parity_mute
  import uart_rx_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Configuration
  input  wire logic       rx_enable,
  input  wire logic       tx_enable,
  input  wire logic       word_9bit,
  input  wire logic       parity_enable,
  input  wire logic       parity_odd_select,
  input  wire logic       parity_irq_enable,
  input  wire logic       wake_method,
  input  wire logic [1:0] base_divisor_select,
  input  wire logic [2:0] tx_rate_select,
  input  wire logic [2:0] rx_rate_select,
  input  wire logic [7:0] tx_fine_divisor,
  input  wire logic [7:0] rx_fine_divisor,
  // Mute control
  input  wire logic       mute_write,
  input  wire logic       mute_write_value,
  output logic            receiver_mute,
  // Software access strobes
  input  wire logic       status_read,
  input  wire logic       data_read,
  // Receive data and status
  output word_t           rx_data,
  output logic            rx_full_flag,
  output logic            framing_error_flag,
  output logic            noise_flag,
  output logic            parity_error_flag,
  output logic            overrun_flag,
  output logic            idle_flag,
  output logic            parity_irq,
  // Transmit
  input  wire logic       tx_write,
  input  wire word_t      tx_data,
  output logic            tx_busy,
  // Serial line
  input  wire logic       rx_line,
  output logic            tx_line
);

  // ************************************************************
  // Rate generation
  // ************************************************************
  logic [3:0] base_cnt_reg;
  logic [3:0] base_limit;
  logic       base_tick;
  logic [1:0] path_tick;
  logic [2:0] path_sel  [2];
  logic [7:0] path_fine [2];
  logic [1:0] path_on;

  always_comb
  begin
    case (base_divisor_select)
      2'b00:   base_limit = `BASE_DIV_SEL1 - 4'h1;
      2'b01:   base_limit = `BASE_DIV_SEL3 - 4'h1;
      2'b10:   base_limit = `BASE_DIV_SEL4 - 4'h1;
      default: base_limit = `BASE_DIV_SEL13 - 4'h1;
    endcase
  end

  assign base_tick = (base_cnt_reg >= base_limit);

  always_ff @(posedge sys_clk)
  begin
    if (reset || base_tick)
      base_cnt_reg <= 4'h0;
    else
      base_cnt_reg <= base_cnt_reg + 4'h1;
  end

  assign path_sel[0]  = tx_rate_select;
  assign path_sel[1]  = rx_rate_select;
  assign path_fine[0] = tx_fine_divisor;
  assign path_fine[1] = rx_fine_divisor;
  assign path_on      = {rx_enable, tx_enable};

  // Paths share the base stage but count on their own from there
  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_path
      logic [6:0] pow_cnt_reg;
      logic [7:0] fine_cnt_reg;
      logic [6:0] pow_limit;
      logic [7:0] fine_limit;
      logic       pow_tick;
      assign pow_limit  = 7'((8'h01 << path_sel[p]) - 8'h01);
      assign pow_tick   = base_tick && (pow_cnt_reg >= pow_limit);
      assign fine_limit = (path_fine[p] == 8'h00) ? 8'h00
                          : path_fine[p] - 8'h01;
      assign path_tick[p] = pow_tick && (fine_cnt_reg >= fine_limit);

      always_ff @(posedge sys_clk)
      begin
        if (reset || !path_on[p] || pow_tick)
          pow_cnt_reg <= 7'h00;
        else if (base_tick)
          pow_cnt_reg <= pow_cnt_reg + 7'h01;
      end

      always_ff @(posedge sys_clk)
      begin
        if (reset || !path_on[p] || path_tick[p])
          fine_cnt_reg <= 8'h00;
        else if (pow_tick)
          fine_cnt_reg <= fine_cnt_reg + 8'h01;
      end
    end
  endgenerate

  // ************************************************************
  // Receiver sampling
  // ************************************************************
  rx_state_e  rx_state_reg;
  logic [3:0] smp_cnt_reg;
  logic [3:0] bit_idx_reg;
  logic [2:0] hist_reg;
  logic       s8_reg;
  logic       s9_reg;
  logic       frame_noise_reg;
  logic       held_noise_reg;
  word_t      shift_reg;
  logic       done_reg;
  logic       done_fe_reg;
  logic       done_noise_reg;
  logic       done_pe_reg;
  word_t      done_word_reg;
  logic       done_addr_reg;
  logic       rx_tick;
  logic       vote;
  logic       agree;
  logic [3:0] n_bits;
  logic [3:0] msb_idx;
  logic       par_bad;

  assign rx_tick = path_tick[1];
  assign vote    = (s8_reg & s9_reg) | (s8_reg & rx_line)
                   | (s9_reg & rx_line);
  assign agree   = (s8_reg == s9_reg) && (s9_reg == rx_line);
  assign n_bits  = word_9bit ? `DATA_BITS_LONG : `DATA_BITS_SHORT;
  assign msb_idx = n_bits - 4'h1 - {3'h0, parity_enable};
  // Over the whole field the parity bit joins the low data bits
  assign par_bad = parity_enable
                   && ((^(shift_reg & ((9'h001 << n_bits) - 9'h001)))
                       != parity_odd_select);

  always_ff @(posedge sys_clk)
  begin
    if (reset || !rx_enable)
      hist_reg <= 3'b111;
    else if (rx_tick)
      hist_reg <= {hist_reg[1:0], rx_line};
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset || !rx_enable)
    begin
      rx_state_reg    <= RX_HUNT;
      smp_cnt_reg     <= 4'h0;
      bit_idx_reg     <= 4'h0;
      s8_reg          <= 1'b1;
      s9_reg          <= 1'b1;
      frame_noise_reg <= 1'b0;
      held_noise_reg  <= 1'b0;
      shift_reg       <= '0;
    end
    else if (rx_tick)
    begin
      smp_cnt_reg <= smp_cnt_reg + 4'h1;
      if (smp_cnt_reg == `SMP_IDX_8)
        s8_reg <= rx_line;
      if (smp_cnt_reg == `SMP_IDX_9)
        s9_reg <= rx_line;
      case (rx_state_reg)
        RX_HUNT:
        begin
          smp_cnt_reg <= 4'h1;
          if (!rx_line)
          begin
            rx_state_reg    <= RX_START;
            frame_noise_reg <= held_noise_reg || (hist_reg != 3'b111);
            held_noise_reg  <= 1'b0;
            shift_reg       <= '0;
          end
        end
        RX_START:
        begin
          if (rx_line && ((smp_cnt_reg == `SMP_IDX_3)
              || (smp_cnt_reg == `SMP_IDX_5)
              || (smp_cnt_reg == `SMP_IDX_7)))
            frame_noise_reg <= 1'b1;
          if (smp_cnt_reg == `SMP_IDX_10)
          begin
            if (!agree || rx_line)
              frame_noise_reg <= 1'b1;
            if (vote)
            begin
              rx_state_reg   <= RX_HUNT;
              held_noise_reg <= 1'b1;
            end
          end
          if (smp_cnt_reg == `SMP_IDX_LAST)
          begin
            rx_state_reg <= RX_DATA;
            bit_idx_reg  <= 4'h0;
          end
        end
        RX_DATA:
        begin
          if (smp_cnt_reg == `SMP_IDX_10)
          begin
            shift_reg[bit_idx_reg] <= vote;
            if (!agree)
              frame_noise_reg <= 1'b1;
          end
          if (smp_cnt_reg == `SMP_IDX_LAST)
          begin
            bit_idx_reg <= bit_idx_reg + 4'h1;
            if (bit_idx_reg == n_bits - 4'h1)
              rx_state_reg <= RX_STOP;
          end
        end
        default:
        begin
          // Ends at the stop bit's centre so the next edge is not missed
          if (smp_cnt_reg == `SMP_IDX_10)
            rx_state_reg <= RX_HUNT;
        end
      endcase
    end
  end

  // Frame result, one cycle pulse
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      done_reg       <= 1'b0;
      done_fe_reg    <= 1'b0;
      done_noise_reg <= 1'b0;
      done_pe_reg    <= 1'b0;
      done_addr_reg  <= 1'b0;
      done_word_reg  <= '0;
    end
    else
    begin
      done_reg <= rx_enable && rx_tick && (rx_state_reg == RX_STOP)
                  && (smp_cnt_reg == `SMP_IDX_10);
      done_fe_reg    <= !vote;
      done_noise_reg <= frame_noise_reg || !agree;
      done_pe_reg    <= par_bad;
      done_addr_reg  <= shift_reg[msb_idx];
      done_word_reg  <= shift_reg;
    end
  end

  // ************************************************************
  // Idle line detection
  // ************************************************************
  logic [7:0] idle_cnt_reg;
  logic       idle_armed_reg;
  logic       idle_hit;
  logic [7:0] idle_len;

  // A whole frame of ones: start, data and stop slots
  assign idle_len = {4'h0, n_bits + 4'h2} * 8'(`SAMPLES_PER_BIT);
  assign idle_hit = rx_enable && rx_tick && idle_armed_reg && rx_line
                    && (rx_state_reg == RX_HUNT)
                    && (idle_cnt_reg == idle_len - 8'h01);

  always_ff @(posedge sys_clk)
  begin
    if (reset || !rx_enable || !rx_line || rx_state_reg != RX_HUNT)
      idle_cnt_reg <= 8'h00;
    else if (rx_tick && idle_cnt_reg != idle_len - 8'h01)
      idle_cnt_reg <= idle_cnt_reg + 8'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset || done_reg)
      idle_armed_reg <= 1'b1;
    else if (idle_hit)
      idle_armed_reg <= 1'b0;
  end

  // ************************************************************
  // Mute and flags
  // ************************************************************
  logic clear_armed_reg;
  logic clear_now;
  logic take;
  logic wake_addr;

  assign wake_addr = receiver_mute && wake_method && done_addr_reg;
  // Frame counts as received when not muted, or when it is the address
  assign take      = done_reg && (!receiver_mute || wake_addr);
  assign clear_now = data_read && clear_armed_reg;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      clear_armed_reg <= 1'b0;
    else if (status_read)
      clear_armed_reg <= 1'b1;
    else if (data_read)
      clear_armed_reg <= 1'b0;
  end

  // A software write wins over a same-cycle wake-up
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      receiver_mute <= `RESET_MUTE;
    else if (mute_write)
      receiver_mute <= mute_write_value;
    else if (idle_hit && !wake_method)
      receiver_mute <= 1'b0;
    else if (done_reg && wake_addr)
      receiver_mute <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rx_data <= '0;
    else if (take && !rx_full_flag)
      rx_data <= done_word_reg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rx_full_flag       <= 1'b0;
      framing_error_flag <= 1'b0;
      noise_flag         <= 1'b0;
      parity_error_flag  <= 1'b0;
      overrun_flag       <= 1'b0;
    end
    else if (take && rx_full_flag)
      overrun_flag <= 1'b1;
    else if (take)
    begin
      rx_full_flag <= 1'b1;
      // Set wins over a same-cycle clear, error bits reload per word
      framing_error_flag <= done_fe_reg;
      noise_flag         <= done_noise_reg;
      parity_error_flag  <= done_pe_reg;
      if (clear_now)
        overrun_flag <= 1'b0;
    end
    else if (clear_now)
    begin
      rx_full_flag       <= 1'b0;
      framing_error_flag <= 1'b0;
      noise_flag         <= 1'b0;
      parity_error_flag  <= 1'b0;
      overrun_flag       <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      idle_flag <= 1'b0;
    else if (idle_hit && !receiver_mute)
      idle_flag <= 1'b1;
    else if (clear_now)
      idle_flag <= 1'b0;
  end

  assign parity_irq = parity_error_flag && parity_irq_enable;

  // ************************************************************
  // Transmitter
  // ************************************************************
  logic [10:0] tx_frame_reg;
  logic [3:0]  tx_smp_reg;
  logic [3:0]  tx_left_reg;
  word_t       tx_word;
  logic        tx_par;
  logic [10:0] tx_build;

  // Parity over the bits below the replaced top bit
  assign tx_par = (^(tx_data & ((9'h001 << (n_bits - 4'h1)) - 9'h001)))
                  ^ parity_odd_select;

  always_comb
  begin
    tx_word = tx_data & ((9'h001 << n_bits) - 9'h001);
    if (parity_enable)
      tx_word[n_bits - 4'h1] = tx_par;
    tx_build = {1'b1, tx_word, 1'b0} | ~((11'h002 << n_bits) - 11'h001);
  end

  // Word written while a frame is out is dropped: no holding buffer
  always_ff @(posedge sys_clk)
  begin
    if (reset || !tx_enable)
    begin
      tx_frame_reg <= '1;
      tx_smp_reg   <= 4'h0;
      tx_left_reg  <= 4'h0;
      tx_line      <= `RESET_LINE;
    end
    else if (tx_left_reg == 4'h0)
    begin
      tx_line <= 1'b1;
      if (tx_write)
      begin
        tx_frame_reg <= tx_build;
        tx_left_reg  <= n_bits + 4'h2;
        tx_smp_reg   <= 4'h0;
      end
    end
    else if (path_tick[0])
    begin
      tx_line    <= tx_frame_reg[0];
      tx_smp_reg <= tx_smp_reg + 4'h1;
      if (tx_smp_reg == `SMP_IDX_LAST)
      begin
        tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
        tx_left_reg  <= tx_left_reg - 4'h1;
      end
    end
  end

  assign tx_busy = (tx_left_reg != 4'h0);

endmodule : uart_rx_baud_parity_mute
`default_nettype wire

//--- tb/uart_rx_checker.sv
`timescale 1ns/1ps
`default_nettype none
module uart_rx_checker (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       reset,
  // Settings and strobes
  input wire logic       parity_irq_enable,
  input wire logic [1:0] base_divisor_select,
  input wire logic [2:0] tx_rate_select,
  input wire logic [7:0] tx_fine_divisor,
  input wire logic       status_read,
  input wire logic       data_read,
  // Observed outputs
  input wire logic       receiver_mute,
  input wire logic       rx_full_flag,
  input wire logic       framing_error_flag,
  input wire logic       noise_flag,
  input wire logic       parity_error_flag,
  input wire logic       idle_flag,
  input wire logic       parity_irq,
  input wire logic       tx_busy,
  input wire logic       tx_line
);
  // ********************
  // Helper logic
  // ********************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic        armed_reg;
  logic        last_reg;
  logic        seen_reg;
  logic [31:0] run_reg;
  logic [31:0] base;
  logic [31:0] fine;
  logic [31:0] bit_clks;
  assign base = (base_divisor_select == 2'h0) ? 32'h1 :
                (base_divisor_select == 2'h1) ? 32'h3 :
                (base_divisor_select == 2'h2) ? 32'h4 : 32'hD;
  assign fine = (tx_fine_divisor == 8'h0) ? 32'h1 : {24'h0, tx_fine_divisor};
  assign bit_clks = base * fine * (32'h10 << tx_rate_select);
  always_ff @(posedge sys_clk)
  begin
    if (reset || status_read)
      armed_reg <= !reset;
    else if (data_read)
      armed_reg <= 1'b0;
  end
  // Run length of each line level; only runs inside one frame are judged
  always_ff @(posedge sys_clk)
  begin
    last_reg <= tx_line;
    run_reg  <= (tx_line != last_reg) ? 32'h1 : run_reg + 32'h1;
    if (reset || !tx_busy)
      seen_reg <= 1'b0;
    else if (tx_line != last_reg)
      seen_reg <= 1'b1;
  end
  // ********************
  // Properties
  // ********************
  property p_fe_full; $rose(framing_error_flag) |-> rx_full_flag; endproperty
  a_fe_full: assert property (p_fe_full)
    else $error("framing flag rose without receive-full");
  property p_pe_full; $rose(parity_error_flag) |-> rx_full_flag; endproperty
  a_pe_full: assert property (p_pe_full)
    else $error("parity flag rose without receive-full");
  property p_pirq;
    parity_irq == (parity_error_flag && parity_irq_enable);
  endproperty
  a_pirq: assert property (p_pirq)
    else $error("parity interrupt differs from flag and enable");
  property p_clear;
    data_read && armed_reg && !status_read
      |=> !framing_error_flag && !noise_flag && !parity_error_flag;
  endproperty
  a_clear: assert property (p_clear)
    else $error("read sequence left an error flag set");
  property p_fe_hold; $fell(framing_error_flag) |-> $past(data_read); endproperty
  a_fe_hold: assert property (p_fe_hold)
    else $error("framing flag fell without a data read");
  property p_mute_full; $rose(rx_full_flag) |-> !receiver_mute; endproperty
  a_mute_full: assert property (p_mute_full)
    else $error("receive-full rose while muted");
  property p_idle; $rose(idle_flag) |-> !$past(receiver_mute); endproperty
  a_idle: assert property (p_idle)
    else $error("idle flag rose while muted");
  property p_tx_bit;
    (tx_line != last_reg) && seen_reg |-> (run_reg % bit_clks) == 32'h0;
  endproperty
  a_tx_bit: assert property (p_tx_bit)
    else $error("transmit bit length off the divided rate");
  c_fe: cover property ($rose(framing_error_flag));
  c_wake: cover property ($fell(receiver_mute));
  c_idle: cover property ($rose(idle_flag));
endmodule : uart_rx_checker
`default_nettype wire

//--- tb/uart_remote_node.sv
`timescale 1ns/1ps
`default_nettype none
module uart_remote_node (
  // Clock
  input  wire logic sys_clk,
  // Serial lines
  input  wire logic tx_line,
  output logic      rx_line
);
  initial rx_line = 1'b1;
  // Frame goes LSB first; bit gb may carry a short inverted glitch
  task automatic send(input logic [11:0] f, input int n, input int bc,
                      input int gb, input int g0, input int gl);
    for (int i = 0; i < n; i++)
      for (int c = 0; c < bc; c++)
      begin
        @(negedge sys_clk);
        rx_line = f[i] ^ (i == gb && c >= g0 && c < g0 + gl);
      end
    @(negedge sys_clk);
    rx_line = 1'b1;
  endtask : send
  // Start length is measured, so the first data bit must be a one
  task automatic grab(input int n, input int bc, output logic [11:0] f,
                      output int lo);
    lo = 0;
    f = 12'h000;
    while (tx_line !== 1'b0)
      @(negedge sys_clk);
    while (tx_line === 1'b0)
    begin
      @(negedge sys_clk);
      lo++;
    end
    repeat (bc / 2) @(negedge sys_clk);
    f[1] = tx_line;
    for (int i = 2; i < n; i++)
    begin
      repeat (bc) @(negedge sys_clk);
      f[i] = tx_line;
    end
  endtask : grab
endmodule : uart_remote_node
`default_nettype wire

//--- tb/uart_rx_baud_parity_mute_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uart_rx_baud_parity_mute_tb
  import uart_rx_pkg::*;
();
  // ********************
  // Design and partner
  // ********************
  logic sys_clk, reset, rx_enable, tx_enable, word_9bit, parity_enable;
  logic parity_odd_select, parity_irq_enable, wake_method, tx_write;
  logic mute_write, mute_write_value, status_read, data_read;
  logic [1:0] base_divisor_select;
  logic [2:0] tx_rate_select, rx_rate_select;
  logic [7:0] tx_fine_divisor, rx_fine_divisor;
  word_t tx_data, rx_data, r;
  logic receiver_mute, rx_full_flag, framing_error_flag, noise_flag;
  logic parity_error_flag, overrun_flag, idle_flag, parity_irq, tx_busy;
  logic rx_line, tx_line;
  logic [3:0] fl4;
  logic [11:0] f;
  int seed = 32'hcdb5;
  int mismatches = 0;
  int num_checks = 0;
  int lo, nb, bc;
  // A low stop bit leaves a false start behind; its noise joins the next word
  logic held_noise = 1'b0;
  assign fl4 = {rx_full_flag, framing_error_flag, noise_flag,
                parity_error_flag};
  uart_rx_baud_parity_mute i_uart_rx_baud_parity_mute (
    .sys_clk, .reset, .rx_enable, .tx_enable, .word_9bit, .parity_enable,
    .parity_odd_select, .parity_irq_enable, .wake_method,
    .base_divisor_select, .tx_rate_select, .rx_rate_select,
    .tx_fine_divisor, .rx_fine_divisor, .mute_write, .mute_write_value,
    .receiver_mute, .status_read, .data_read, .rx_data, .rx_full_flag,
    .framing_error_flag, .noise_flag, .parity_error_flag, .overrun_flag,
    .idle_flag, .parity_irq, .tx_write, .tx_data, .tx_busy, .rx_line,
    .tx_line);
  uart_remote_node i_uart_remote_node (.sys_clk, .tx_line, .rx_line);
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ********************
  // Expectations and tasks
  // ********************
  function automatic word_t fld(input word_t d);
    word_t m;
    m = 9'h1FF >> (9 - nb);
    fld = d & m;
    if (parity_enable)
      fld[nb - 1] = ^(d & (m >> 1)) ^ parity_odd_select;
  endfunction : fld
  function automatic logic [11:0] frm(input word_t v);
    return {2'h0, v, 1'b0} | (12'h001 << (nb + 1));
  endfunction : frm
  function automatic int bclk(input logic [1:0] b, input logic [2:0] s,
                              input logic [7:0] fd);
    int pr;
    pr = (b == 2'h0) ? 1 : (b == 2'h1) ? 3 : (b == 2'h2) ? 4 : 13;
    return 16 * pr * (1 << s) * ((fd == 8'h00) ? 1 : int'(fd));
  endfunction : bclk
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic setfmt(input logic [1:0] m);
    {word_9bit, parity_enable} = m;
    nb = m[1] ? 9 : 8;
  endtask : setfmt
  task automatic pulse_mute();
    mute_write = 1'b1;
    mute_write_value = 1'b1;
    @(negedge sys_clk);
    mute_write = 1'b0;
  endtask : pulse_mute
  task automatic rd();
    status_read = 1'b1;
    @(negedge sys_clk);
    status_read = 1'b0;
    data_read = 1'b1;
    @(negedge sys_clk);
    data_read = 1'b0;
    @(negedge sys_clk);
    chk("cleared", fl4, 16'h0);
  endtask : rd
  task automatic rxf(input word_t v, input word_t e, input logic [3:0] fl,
                     input int gb, input int g0, input logic [11:0] x);
    i_uart_remote_node.send(frm(v) ^ x, nb + 2, 64, gb, g0, 4);
    repeat (8) @(negedge sys_clk);
    chk("rx_data", rx_data, e);
    chk("rx_flags", fl4, fl | {2'b00, held_noise, 1'b0});
    held_noise = 1'b0;
  endtask : rxf
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    results();
  end
  // ********************
  // Tests
  // ********************
  initial
  begin
    {reset, rx_enable, tx_enable, parity_odd_select} = 4'hE;
    {parity_irq_enable, wake_method, mute_write, mute_write_value} = 4'h0;
    {status_read, data_read, tx_write} = 3'h0;
    {base_divisor_select, tx_rate_select, rx_rate_select} = 8'h02;
    {tx_fine_divisor, rx_fine_divisor, tx_data} = 25'h0;
    setfmt(2'h0);
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    chk("reset", {fl4, overrun_flag, idle_flag, receiver_mute, tx_busy,
                  tx_line, rx_data}, 16'h0200);
    $display("test reset done");
    for (int m = 0; m < 4; m++)
    begin
      setfmt(2'(m));
      parity_odd_select = 1'($random(seed));
      parity_irq_enable = m[1];
      r = fld(9'($random(seed)));
      rxf(r, r, 4'h8, -1, 0, 12'h0);
      rd();
      rxf(r, r, 4'hC, -1, 0, 12'h001 << (nb + 1));
      held_noise = 1'b1;
      data_read = 1'b1;
      @(negedge sys_clk);
      data_read = 1'b0;
      @(negedge sys_clk);
      chk("fe_held", framing_error_flag, 16'h1);
      rd();
      if (parity_enable)
      begin
        r = r ^ (9'h001 << (nb - 1));
        rxf(r, r, 4'h9, -1, 0, 12'h0);
        chk("parity_irq", parity_irq, 16'(m[1]));
        rd();
      end
    end
    $display("test formats done");
    rx_enable = 1'b0;
    rx_rate_select = 3'h0;
    rx_fine_divisor = 8'h04;
    setfmt(2'h0);
    @(negedge sys_clk);
    rx_enable = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      r = fld(9'($random(seed)));
      rxf(r, r, 4'hA, (k == 0) ? 3 : 0, (k == 2) ? 16 : 32, 12'h0);
      rd();
    end
    i_uart_remote_node.send(12'hFFE, 1, 24, -1, 0, 0);
    repeat (800) @(negedge sys_clk);
    chk("false_start", {rx_full_flag, idle_flag}, 16'h1);
    rxf(9'h05A, 9'h05A, 4'hA, -1, 0, 12'h0);
    rxf(9'h0F0, 9'h05A, 4'hA, -1, 0, 12'h0);
    chk("overrun", overrun_flag, 16'h1);
    rd();
    $display("test noise done");
    setfmt(2'h3);
    parity_odd_select = 1'b1;
    wake_method = 1'b1;
    pulse_mute();
    rxf(9'h100, 9'h05A, 4'h0, -1, 0, 12'h0);
    chk("mute_kept", receiver_mute, 16'h1);
    rxf(9'h080, 9'h080, 4'h8, -1, 0, 12'h0);
    chk("mute_woke", receiver_mute, 16'h0);
    rd();
    wake_method = 1'b0;
    pulse_mute();
    repeat (1000) @(negedge sys_clk);
    chk("idle_wake", {receiver_mute, idle_flag}, 16'h0);
    $display("test mute done");
    rx_enable = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      tx_enable = 1'b0;
      base_divisor_select = 2'(k);
      tx_rate_select = 3'($random(seed)) & 3'h1;
      tx_fine_divisor = k[0] ? 8'h02 : 8'h00;
      setfmt(2'($random(seed)));
      bc = bclk(base_divisor_select, tx_rate_select, tx_fine_divisor);
      @(negedge sys_clk);
      tx_enable = 1'b1;
      tx_data = 9'($random(seed)) | 9'h001;
      tx_write = 1'b1;
      @(negedge sys_clk);
      tx_write = 1'b0;
      i_uart_remote_node.grab(nb + 2, bc, f, lo);
      chk("tx_bit_len", 16'(lo), 16'(bc));
      chk("tx_frame", f, frm(fld(tx_data)));
      for (int w = 0; w < 2 * bc && tx_busy !== 1'b0; w++)
        @(negedge sys_clk);
    end
    $display("test transmit done");
    results();
  end
endmodule : uart_rx_baud_parity_mute_tb
bind uart_rx_baud_parity_mute uart_rx_checker i_uart_rx_checker (
  .sys_clk, .reset, .parity_irq_enable, .base_divisor_select,
  .tx_rate_select, .tx_fine_divisor, .status_read, .data_read,
  .receiver_mute, .rx_full_flag, .framing_error_flag, .noise_flag,
  .parity_error_flag, .idle_flag, .parity_irq, .tx_busy, .tx_line);
`default_nettype wire
